// ===== design/scm_top.sv
/*
 * System clock and operating-mode controller with APB registers.
 * Sequences run, doze, deep-doze, stop and warm-up, builds the
 * machine cycle and the divider chain.
 * Assumes fast_clock and slow_clock are levels synchronous to pclk
 * and well below half its rate.
 */
// Notes on behaviour
// - Prescaler of two stages feeds a 21-stage divider; machine cycle counter follows.
// - Prescaler and divider clear on reset and on entering or leaving stop.
// - Stage seven input depends on mode, clock select and stage-seven select.
// - Slow run and sleep feed stage seven from the slow clock.
// - Warm-up after stop from fast run feeds stage seven from stage six.
// - Machine cycle is four states, one main clock each.
// - Single-clock mode: fast oscillator only, slow pins are ports.
// - Reset enters single-clock run on the fast clock.
// - Doze request with the halt bit clear halts core and watchdog, peripherals keep running.
// - Any interrupt request ends doze; taken when master enable set.
// - Master enable clear: resume after the doze instruction.
// - Deep doze needs the halt bit; only the tick timer keeps clocks.
// - Deep doze ends on the falling edge of the tick source.
// - Deep doze entry and exit ignore the tick timer enable.
// - Tick interrupt taken only with all three enables set.
// - Tick enabled at entry: tick interrupt latch set on return.
// - Dual clock: both oscillators run; fast clock in fast run and doze.
// - Slow run and sleep: main clock from slow clock.
// - Reset gives single-clock mode; software enables slow oscillator.
// - Clock select one goes slow run, zero returns fast run.
// - Clearing fast enable in slow run stops the fast oscillator.
// - Fast oscillator off: stage one input stops, stages one to six idle.
`timescale 1ns/10ps
`default_nettype none

module scm_top
    import scm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fast_clock,
    input  wire logic        slow_clock,
    input  wire logic        irq_request,
    input  wire logic        master_irq_enable,
    input  wire logic        tick_irq_individual_enable,
    input  wire logic        stop_release,
    output logic             main_clk_en,
    output logic [1:0]       machine_state,
    output logic             cpu_run,
    output logic             wdt_run,
    output logic             periph_run,
    output logic             tick_timer_run,
    output logic             fast_osc_on,
    output logic             slow_osc_on,
    output logic             slow_pins_as_port,
    output logic             irq_take,
    output logic             tick_interrupt_latch,
    output logic [20:0]      div_stages
);

    scm_mode_t   mode_r;
    scm_mode_t   ret_mode_r;
    logic [7:0]  ctrl_two_r;
    logic [7:0]  tick_ctrl_r;
    logic        stop_req_r;
    logic        doze_req_r;
    logic        tben_entry_r;
    logic        div_clr_r;
    logic        fc_d_r;
    logic        fs_d_r;
    logic        src_slow_r;
    logic [1:0]  mstate_r;
    logic [20:0] fall;
    logic        fast_tick;
    logic        slow_tick;
    logic        main_tick;
    logic        boundary;
    logic        tick_fall;
    logic        warm_done;
    logic        s7_slow;
    logic        slow_group;
    logic        wr_en;
    logic        consume;
    logic        fast_en;
    logic        slow_en;
    logic        sys_sel;
    logic        halt_bit;

    assign fast_en  = ctrl_two_r[FAST_EN_BIT];
    assign slow_en  = ctrl_two_r[SLOW_EN_BIT];
    assign sys_sel  = ctrl_two_r[SYS_SEL_BIT];
    assign halt_bit = ctrl_two_r[HALT_BIT];

    // ==========================================================
    // oscillator edge pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_d_r <= 1'b0;
            fs_d_r <= 1'b0;
        end else begin
            fc_d_r <= fast_clock;
            fs_d_r <= slow_clock;
        end
    end

    assign fast_tick = fast_clock & ~fc_d_r & fast_osc_on;
    assign slow_tick = slow_clock & ~fs_d_r & slow_osc_on;

    // ==========================================================
    // machine cycle
    assign main_tick = (mode_r != stop_mode) && (mode_r != warm_up_mode)
                       && (src_slow_r ? slow_tick : fast_tick);
    assign boundary  = main_tick && (mstate_r == LAST_STATE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstate_r <= 2'h0;
        end else if (main_tick) begin
            mstate_r <= mstate_r + 2'h1;
        end
    end

    // source swaps when a cycle completes, and in any cycle of warm-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_slow_r <= 1'b0;
        end else if (boundary || mode_r == warm_up_mode) begin
            src_slow_r <= slow_group;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk_en   <= 1'b0;
            machine_state <= 2'h0;
        end else begin
            main_clk_en   <= main_tick;
            machine_state <= mstate_r;
        end
    end

    // ==========================================================
    // divider chain
    assign slow_group = mode_r inside {slow_run_both_osc_mode,
                                       slow_sleep_both_osc_mode,
                                       slow_run_fast_osc_off_mode,
                                       slow_sleep_fast_osc_off_mode,
                                       slow_deep_sleep_mode}
                        || (mode_r == warm_up_mode && ret_mode_r inside
                            {slow_run_both_osc_mode,
                             slow_run_fast_osc_off_mode});

    always_comb begin
        if (slow_group) begin
            s7_slow = 1'b1;
        end else if (mode_r == warm_up_mode) begin
            s7_slow = 1'b0;
        end else begin
            s7_slow = tick_ctrl_r[DV7_SEL_BIT];
        end
    end

    scm_divider u_div (
        .clk          (pclk),
        .rst_n        (presetn),
        .clr          (div_clr_r),
        .in_tick      (fast_tick),
        .stage1_run   (fast_osc_on),
        .s7_from_slow (s7_slow),
        .slow_tick    (slow_tick),
        .div_q        (div_stages),
        .fall         (fall)
    );

    assign tick_fall = fall[tick_stage(tick_ctrl_r[TICK_SEL_LSB +: TICK_SEL_W]) - 1];
    assign warm_done = fall[WARM_STAGE-1];

    // ==========================================================
    // mode sequencer
    assign consume = (boundary && (stop_req_r || doze_req_r))
                     || mode_r == stop_mode;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r               <= single_clock_run_mode;
            ret_mode_r           <= single_clock_run_mode;
            tben_entry_r         <= 1'b0;
            div_clr_r            <= 1'b0;
            irq_take             <= 1'b0;
            tick_interrupt_latch <= 1'b0;
        end else begin
            div_clr_r            <= 1'b0;
            irq_take             <= 1'b0;
            tick_interrupt_latch <= 1'b0;
            unique case (mode_r)
                single_clock_run_mode,
                dual_clock_fast_run_mode,
                slow_run_both_osc_mode,
                slow_run_fast_osc_off_mode: begin
                    if (boundary) begin
                        if (stop_req_r) begin
                            ret_mode_r <= mode_r;
                            mode_r     <= stop_mode;
                            div_clr_r  <= 1'b1;
                        end else if (doze_req_r) begin
                            tben_entry_r <= tick_ctrl_r[TICK_EN_BIT];
                            unique case (mode_r)
                                single_clock_run_mode:
                                    mode_r <= halt_bit ? deep_doze_mode
                                                       : single_clock_doze_mode;
                                dual_clock_fast_run_mode:
                                    mode_r <= dual_clock_doze_mode;
                                slow_run_both_osc_mode:
                                    mode_r <= slow_sleep_both_osc_mode;
                                default:
                                    mode_r <= halt_bit ? slow_deep_sleep_mode
                                                       : slow_sleep_fast_osc_off_mode;
                            endcase
                        end else begin
                            unique case (mode_r)
                                single_clock_run_mode:
                                    if (slow_en) mode_r <= dual_clock_fast_run_mode;
                                dual_clock_fast_run_mode:
                                    if (sys_sel) mode_r <= slow_run_both_osc_mode;
                                    else if (!slow_en) mode_r <= single_clock_run_mode;
                                slow_run_both_osc_mode:
                                    if (!sys_sel) mode_r <= dual_clock_fast_run_mode;
                                    else if (!fast_en) mode_r <= slow_run_fast_osc_off_mode;
                                default:
                                    if (fast_en) mode_r <= slow_run_both_osc_mode;
                            endcase
                        end
                    end
                end
                single_clock_doze_mode: begin
                    if (irq_request) begin
                        mode_r   <= single_clock_run_mode;
                        irq_take <= master_irq_enable;
                    end
                end
                dual_clock_doze_mode: begin
                    if (irq_request) begin
                        mode_r   <= dual_clock_fast_run_mode;
                        irq_take <= master_irq_enable;
                    end
                end
                slow_sleep_both_osc_mode: begin
                    if (irq_request) begin
                        mode_r   <= slow_run_both_osc_mode;
                        irq_take <= master_irq_enable;
                    end
                end
                slow_sleep_fast_osc_off_mode: begin
                    if (irq_request) begin
                        mode_r   <= slow_run_fast_osc_off_mode;
                        irq_take <= master_irq_enable;
                    end
                end
                deep_doze_mode,
                slow_deep_sleep_mode: begin
                    if (tick_fall) begin
                        mode_r <= (mode_r == deep_doze_mode)
                                  ? single_clock_run_mode
                                  : slow_run_fast_osc_off_mode;
                        irq_take <= master_irq_enable
                                    && tick_irq_individual_enable
                                    && tick_ctrl_r[TICK_EN_BIT];
                        tick_interrupt_latch <= tben_entry_r;
                    end
                end
                stop_mode: begin
                    if (stop_release) begin
                        mode_r    <= warm_up_mode;
                        div_clr_r <= 1'b1;
                    end
                end
                warm_up_mode: begin
                    if (warm_done) begin
                        mode_r <= ret_mode_r;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // clock gates and oscillator controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_run           <= 1'b1;
            wdt_run           <= 1'b1;
            periph_run        <= 1'b1;
            tick_timer_run    <= 1'b1;
            fast_osc_on       <= 1'b1;
            slow_osc_on       <= 1'b0;
            slow_pins_as_port <= 1'b1;
        end else begin
            cpu_run <= mode_r inside {single_clock_run_mode,
                                      dual_clock_fast_run_mode,
                                      slow_run_both_osc_mode,
                                      slow_run_fast_osc_off_mode};
            wdt_run <= mode_r inside {single_clock_run_mode,
                                      dual_clock_fast_run_mode,
                                      slow_run_both_osc_mode,
                                      slow_run_fast_osc_off_mode};
            periph_run <= !(mode_r inside {deep_doze_mode,
                                           slow_deep_sleep_mode,
                                           stop_mode,
                                           warm_up_mode});
            tick_timer_run <= !(mode_r inside {stop_mode, warm_up_mode});
            fast_osc_on <= !(mode_r inside {slow_run_fast_osc_off_mode,
                                            slow_sleep_fast_osc_off_mode,
                                            slow_deep_sleep_mode,
                                            stop_mode})
                           && !(mode_r == warm_up_mode
                                && ret_mode_r == slow_run_fast_osc_off_mode);
            slow_osc_on <= !(mode_r inside {single_clock_run_mode,
                                            single_clock_doze_mode,
                                            deep_doze_mode,
                                            stop_mode})
                           && !(mode_r == warm_up_mode
                                && ret_mode_r == single_clock_run_mode);
            slow_pins_as_port <= mode_r inside {single_clock_run_mode,
                                                single_clock_doze_mode,
                                                deep_doze_mode};
        end
    end

    // ==========================================================
    // APB slave, two-cycle access phase
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready
                       && !(paddr inside {CTRL_ONE_OFS, CTRL_TWO_OFS,
                                          TICK_CTRL_OFS, STATUS_OFS});
            prdata  <= 32'h0;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    CTRL_ONE_OFS:  prdata[STOP_BIT] <= stop_req_r;
                    CTRL_TWO_OFS:  prdata[7:0] <= {ctrl_two_r[7:5],
                                                   doze_req_r,
                                                   ctrl_two_r[3:0]};
                    TICK_CTRL_OFS: prdata[7:0] <= tick_ctrl_r;
                    STATUS_OFS:    prdata[7:0] <= {slow_osc_on, fast_osc_on,
                                                   mstate_r, mode_r};
                    default:       prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_two_r  <= CTRL_TWO_RST;
            tick_ctrl_r <= TICK_CTRL_RST;
        end else if (wr_en) begin
            if (paddr == CTRL_TWO_OFS) begin
                ctrl_two_r <= pwdata[7:0] & 8'hEF;
            end
            if (paddr == TICK_CTRL_OFS) begin
                tick_ctrl_r <= pwdata[7:0];
            end
        end
    end

    // request flags: a write in the consuming cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_req_r <= 1'b0;
            doze_req_r <= 1'b0;
        end else begin
            if (consume) begin
                stop_req_r <= 1'b0;
                doze_req_r <= stop_req_r && doze_req_r;
            end
            if (wr_en && paddr == CTRL_ONE_OFS && pwdata[STOP_BIT]) begin
                stop_req_r <= 1'b1;
            end
            if (wr_en && paddr == CTRL_TWO_OFS && pwdata[DOZE_BIT]) begin
                doze_req_r <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== design/scm_pkg.sv
/*
 * Shared constants of the system clock and mode controller: register
 * offsets, field positions, reset values, divider geometry, mode codes.
 * Assumes a 32-bit APB register bus and a 50 MHz pclk.
 */
package scm_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_ONE_OFS  = 8'h00;
    localparam logic [7:0] CTRL_TWO_OFS  = 8'h04;
    localparam logic [7:0] TICK_CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS    = 8'h0C;

    // ==========================================================
    // field positions
    localparam int unsigned STOP_BIT     = 7;
    localparam int unsigned FAST_EN_BIT  = 7;
    localparam int unsigned SLOW_EN_BIT  = 6;
    localparam int unsigned SYS_SEL_BIT  = 5;
    localparam int unsigned DOZE_BIT     = 4;
    localparam int unsigned HALT_BIT     = 2;
    localparam int unsigned DV7_SEL_BIT  = 7;
    localparam int unsigned TICK_EN_BIT  = 3;
    localparam int unsigned TICK_SEL_LSB = 0;
    localparam int unsigned TICK_SEL_W   = 3;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_TWO_RST  = 8'h80;
    localparam logic [7:0] TICK_CTRL_RST = 8'h00;

    // ==========================================================
    // timing generator geometry
    localparam int unsigned PRESCALE_STAGES = 2;
    localparam int unsigned DIV_STAGES      = 21;
    localparam int unsigned DIV7_STAGE      = 7;
    localparam int unsigned WARM_STAGE      = 14;
    localparam logic [1:0]  LAST_STATE      = 2'h3;

    // divider stage whose falling edge clocks the tick timer
    function automatic int unsigned tick_stage(input logic [2:0] sel);
        int unsigned s;
        s = 21;
        unique case (sel)
            3'h0: s = 21;
            3'h1: s = 20;
            3'h2: s = 15;
            3'h3: s = 13;
            3'h4: s = 12;
            3'h5: s = 11;
            3'h6: s = 10;
            3'h7: s = 9;
        endcase
        return s;
    endfunction

    // ==========================================================
    // operating modes
    typedef enum logic [3:0] {
        single_clock_run_mode,
        single_clock_doze_mode,
        deep_doze_mode,
        dual_clock_fast_run_mode,
        dual_clock_doze_mode,
        slow_run_both_osc_mode,
        slow_sleep_both_osc_mode,
        slow_run_fast_osc_off_mode,
        slow_sleep_fast_osc_off_mode,
        slow_deep_sleep_mode,
        stop_mode,
        warm_up_mode
    } scm_mode_t;

endpackage

// ===== design/scm_divider.sv
/*
 * Timing generator: prescaler feeding a binary divider whose stage
 * seven input is chosen by the caller. Each stage toggles on the
 * falling edge of the one before, modelled as clock enables.
 * Assumes in_tick and slow_tick are one-cycle pulses on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module scm_divider
    import scm_pkg::*;
#(
    parameter int unsigned PRE_W = PRESCALE_STAGES,
    parameter int unsigned DIV_W = DIV_STAGES,
    parameter int unsigned S7    = DIV7_STAGE
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clr,
    input  wire logic             in_tick,
    input  wire logic             stage1_run,
    input  wire logic             s7_from_slow,
    input  wire logic             slow_tick,
    output logic [DIV_W-1:0]      div_q,
    output logic [DIV_W-1:0]      fall
);

    if (PRE_W < 1 || S7 < 2 || S7 > DIV_W) begin : g_bad
        $error("scm_divider: unsupported geometry");
    end

    logic [PRE_W-1:0] pre_r;
    logic [DIV_W-1:0] tick;
    logic             pre_step;

    // ==========================================================
    // prescaler
    assign pre_step = in_tick & stage1_run;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
        end else if (clr) begin
            pre_r <= '0;
        end else if (pre_step) begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // ==========================================================
    // divider stages
    for (genvar i = 0; i < DIV_W; i++) begin : g_stage
        if (i == 0) begin : g_first
            assign tick[i] = pre_step & (&pre_r);
        end else if (i == S7 - 1) begin : g_seven
            assign tick[i] = s7_from_slow ? slow_tick : fall[i-1];
        end else begin : g_next
            assign tick[i] = fall[i-1];
        end
        assign fall[i] = tick[i] & div_q[i];

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                div_q[i] <= 1'b0;
            end else if (clr) begin
                div_q[i] <= 1'b0;
            end else if (tick[i]) begin
                div_q[i] <= ~div_q[i];
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/scm_props.sv
/* checker of scm_top port relations; assumes it is bound to scm_top */
`timescale 1ns/10ps
`default_nettype none
module scm_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [1:0]  machine_state,
    input wire logic        main_clk_en,
    input wire logic        slow_pins_as_port,
    input wire logic        slow_osc_on,
    input wire logic        fast_osc_on,
    input wire logic        cpu_run,
    input wire logic        wdt_run,
    input wire logic        periph_run,
    input wire logic        tick_timer_run,
    input wire logic        irq_take,
    input wire logic        master_irq_enable,
    input wire logic [20:0] div_stages
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // assertions
    chk_state_step: assert property ($changed(machine_state) |-> machine_state == $past(machine_state) + 2'h1)
        else $error("machine state skipped");
    chk_tick_single: assert property (main_clk_en |=> !main_clk_en) else $error("main tick doubled");
    chk_single_slow_off: assert property (slow_pins_as_port |-> !slow_osc_on) else $error("slow osc on");
    chk_dual_slow_on: assert property (!slow_pins_as_port && tick_timer_run |-> slow_osc_on) else $error("slow osc off");
    chk_doze_halts: assert property (!cpu_run |-> !wdt_run) else $error("watchdog runs");
    chk_deep_gates: assert property (!periph_run |-> !cpu_run) else $error("core runs");
    chk_div_idle: assert property (!fast_osc_on && $past(!fast_osc_on) && tick_timer_run && $past(tick_timer_run)
        |-> $stable(div_stages[5:0])) else $error("low stages moved");
    chk_take_enabled: assert property (irq_take |-> master_irq_enable || $past(master_irq_enable))
        else $error("irq taken while disabled");
endmodule
bind scm_top scm_props u_props (.pclk(pclk), .presetn(presetn), .machine_state(machine_state),
    .main_clk_en(main_clk_en), .slow_pins_as_port(slow_pins_as_port), .slow_osc_on(slow_osc_on),
    .fast_osc_on(fast_osc_on), .cpu_run(cpu_run), .wdt_run(wdt_run), .periph_run(periph_run),
    .tick_timer_run(tick_timer_run), .irq_take(irq_take), .master_irq_enable(master_irq_enable),
    .div_stages(div_stages));
`default_nettype wire

// ===== tb/scm_top_tb.sv
/* bench of scm_top; drives APB and oscillator levels itself */
`timescale 1ns/10ps
`default_nettype none
module scm_top_tb;
    import scm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq = 0, mie = 1, fclk = 0, sclk = 0;
    logic ef = 1, srel = 0, seen = 0;
    logic [20:0] div;
    logic [7:0] paddr = 8'h00, cnt = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, cpu_run, wdt_run, periph_run, tt_run, fast_on, slow_on, port, take, tlat;
    int fails = 0, n_tests = 0, i;
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cnt <= cnt + 8'h01;
        fclk <= cnt[1];
        sclk <= cnt[4];
    end
    scm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_clock(fclk), .slow_clock(sclk), .irq_request(irq), .master_irq_enable(mie),
        .tick_irq_individual_enable(ef), .stop_release(srel), .main_clk_en(), .machine_state(),
        .cpu_run(cpu_run), .wdt_run(wdt_run), .periph_run(periph_run), .tick_timer_run(tt_run),
        .fast_osc_on(fast_on), .slow_osc_on(slow_on), .slow_pins_as_port(port), .irq_take(take),
        .tick_interrupt_latch(tlat), .div_stages(div));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wait_mode(input logic [3:0] m);
        apb(0, STATUS_OFS, 0);
        for (i = 0; i < 400 && q[3:0] !== m; i++) apb(0, STATUS_OFS, 0);
        cmp(q[3:0], m);
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        for (i = 0; i < 20000 && s !== v; i++) @(posedge pclk);
        cmp(s, v);
    endtask
    task conclude;
        $display("mismatches %0d, comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task t_reset;
        apb(0, CTRL_TWO_OFS, 0); cmp(q, 32'h80);
        wait_mode(single_clock_run_mode);
        cmp({port, slow_on, fast_on}, 3'h5);
        apb(0, 8'h40, 0);
        cmp(q, 32'h0);
        cmp(e, 1'b1);
    endtask
    task t_doze(input logic en);
        mie <= en;
        apb(1, CTRL_TWO_OFS, 32'h90);
        wait_sig(cpu_run, 0); cmp({wdt_run, periph_run}, 2'h1);
        irq <= 1;
        seen = 0;
        for (i = 0; i < 200 && cpu_run !== 1'b1; i++) begin
            @(posedge pclk);
            seen |= take;
        end
        cmp(seen, en);
        irq <= 0;
        wait_mode(single_clock_run_mode);
    endtask
    task t_deep;
        mie <= 1;
        ef <= 0;
        apb(1, TICK_CTRL_OFS, 32'h0F);
        apb(1, CTRL_TWO_OFS, 32'h94);
        wait_sig(periph_run, 0); cmp({cpu_run, tt_run}, 2'h1);
        wait_sig(tlat, 1);
        cmp(take, 1'b0);
        wait_mode(single_clock_run_mode);
    endtask
    task t_dual;
        apb(1, CTRL_TWO_OFS, 32'hC0); wait_mode(dual_clock_fast_run_mode);
        apb(1, CTRL_TWO_OFS, 32'hE0); wait_mode(slow_run_both_osc_mode);
        apb(1, CTRL_TWO_OFS, 32'h60); wait_mode(slow_run_fast_osc_off_mode);
        repeat (3) @(posedge pclk);
        cmp({fast_on, port}, 2'h0);
        apb(1, CTRL_TWO_OFS, 32'hE0); wait_mode(slow_run_both_osc_mode);
        apb(1, CTRL_TWO_OFS, 32'hC0); wait_mode(dual_clock_fast_run_mode);
    endtask
    task t_stop;
        apb(1, CTRL_ONE_OFS, 32'h80); wait_mode(stop_mode);
        repeat (2) @(posedge pclk);
        cmp(div, 32'h0);
        srel <= 1;
        wait_mode(warm_up_mode);
        srel <= 0;
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, CTRL_TWO_OFS, 0); cmp(q, 32'h80);
        wait_mode(single_clock_run_mode);
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        conclude;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_reset; t_doze(1); t_doze(0); t_deep; t_dual; t_stop;
        conclude;
    end
endmodule
`default_nettype wire
